// File: bench/smcs_top_test.sv
// self-checking testbench for the clock mode select block
`timescale 1ns/10ps
module smcs_top_test
   import smcs_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic halt_req = 1'b0;
   logic wake_req = 1'b0;
   logic idle_clock_keep = 1'b0;
   logic wdt_enable = 1'b0;
   logic xtal_source = 1'b0;
   logic fast_osc_tick = 1'b0;
   logic slow_osc_tick = 1'b0;
   logic fast_osc_enable, slow_osc_enable, sys_clk_select_slow, cpu_run, sys_clk_run;
   logic [5:0] sys_clk_divide;
   logic [2:0] power_mode;
   int err_total = 0;
   int samples_checked = 0;
   int tick_cnt = 0;
   logic [31:0] rd;
   logic er;

   smcs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .halt_req(halt_req), .wake_req(wake_req),
      .idle_clock_keep(idle_clock_keep), .wdt_enable(wdt_enable), .xtal_source(xtal_source),
      .fast_osc_tick(fast_osc_tick), .slow_osc_tick(slow_osc_tick),
      .fast_osc_enable(fast_osc_enable), .slow_osc_enable(slow_osc_enable),
      .sys_clk_select_slow(sys_clk_select_slow), .sys_clk_divide(sys_clk_divide),
      .cpu_run(cpu_run), .sys_clk_run(sys_clk_run), .power_mode(power_mode));

   // ----------------------------------------
   // clock and oscillator ticks
   // ----------------------------------------
   always #5 pclk = ~pclk;
   // ticks kept well below pclk/4 so the synchronisers never miss an edge
   always @(posedge pclk)
   begin
      tick_cnt <= tick_cnt + 1;
      if (tick_cnt % 3 == 2) fast_osc_tick <= ~fast_osc_tick;
      if (tick_cnt % 5 == 4) slow_osc_tick <= ~slow_osc_tick;
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk("pready", {31'h0, pready}, 32'h0000_0001);
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_regs;
      chk("power_mode", {29'h0, power_mode}, 32'h0000_0000);
      chk("cpu_run", {31'h0, cpu_run}, 32'h0000_0001);
      repeat (300) @(posedge pclk);
      apb(1'b0, SMCS_MODE_CTRL_ADDR, 32'h0000_0000);
      chk("ctrl after reset", rd, 32'h0000_000f);
      apb(1'b1, SMCS_MODE_CTRL_ADDR, 32'h0000_00f3);
      apb(1'b0, SMCS_MODE_CTRL_ADDR, 32'h0000_0000);
      chk("ctrl flags kept", rd, 32'h0000_00ff);
      apb(1'b0, 12'h00c, 32'h0000_0000);
      chk("unmapped err", {31'h0, er}, 32'h0000_0001);
      chk("unmapped data", rd, 32'h0000_0000);
      $display("test reset_regs done");
   endtask

   task automatic t_divider;
      logic [6:0] q;
      for (int c = 7; c >= 0; c--)
      begin
         apb(1'b1, SMCS_MODE_CTRL_ADDR, {24'h0, c[2:0], 5'h00});
         repeat (4) @(posedge pclk);
         if (c >= 2)
         begin
            q = 7'h40 >> (c - 2);
            chk("divide", {26'h0, sys_clk_divide}, {25'h0, q - 7'h01});
            chk("select_slow", {31'h0, sys_clk_select_slow}, 32'h0000_0000);
         end
         else
         begin
            chk("select_slow", {31'h0, sys_clk_select_slow}, 32'h0000_0001);
            chk("fast_enable", {31'h0, fast_osc_enable}, 32'h0000_0000);
         end
      end
      apb(1'b1, SMCS_MODE_CTRL_ADDR, 32'h0000_0003);
      repeat (300) @(posedge pclk);
      chk("divide full", {26'h0, sys_clk_divide}, 32'h0000_0000);
      chk("select_slow", {31'h0, sys_clk_select_slow}, 32'h0000_0000);
      $display("test divider done");
   endtask

   // one halt and wake cycle: ctrl value, keep and watchdog levels, expected mode
   task automatic t_halt(input logic [7:0] ctrl, input logic keep, input logic wdt,
      input logic [2:0] mode, input logic clk_on, input logic [7:0] mask);
      int n;
      apb(1'b1, SMCS_MODE_CTRL_ADDR, {24'h0, ctrl});
      idle_clock_keep <= keep;
      wdt_enable <= wdt;
      repeat (4) @(posedge pclk);
      halt_req <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("halt mode", {29'h0, power_mode}, {29'h0, mode});
      chk("cpu_run", {31'h0, cpu_run}, 32'h0000_0000);
      chk("sys_clk_run", {31'h0, sys_clk_run}, {31'h0, clk_on});
      chk("fast_osc_enable", {31'h0, fast_osc_enable}, {31'h0, clk_on});
      chk("slow_osc_enable", {31'h0, slow_osc_enable}, {31'h0, mode != 3'h4});
      apb(1'b0, SMCS_EVENT_ADDR, 32'h0000_0000);
      chk("event low power", rd, 32'h0000_0001);
      apb(1'b0, SMCS_MODE_CTRL_ADDR, 32'h0000_0000);
      chk("flags asleep", rd & {24'h0, mask}, 32'h0000_0000);
      halt_req <= 1'b0;
      wake_req <= 1'b1;
      n = 0;
      while (power_mode !== SMCS_RUN && n < 3000)
      begin
         @(posedge pclk);
         n++;
      end
      wake_req <= 1'b0;
      chk("woken", {29'h0, power_mode}, 32'h0000_0000);
      repeat (300) @(posedge pclk);
      apb(1'b0, SMCS_MODE_CTRL_ADDR, 32'h0000_0000);
      chk("flags awake", rd & 32'h0000_000c, 32'h0000_000c);
      chk("cpu_run", {31'h0, cpu_run}, 32'h0000_0001);
      $display("test halt mode %0d done", mode);
   endtask

   // crystal with fast wake: slow rc carries the system until the crystal settles
   task automatic t_fast_wake;
      int n;
      xtal_source <= 1'b1;
      wdt_enable <= 1'b1;
      apb(1'b1, SMCS_MODE_CTRL_ADDR, 32'h0000_0011);
      repeat (4) @(posedge pclk);
      halt_req <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("xtal halt mode", {29'h0, power_mode}, 32'h0000_0003);
      halt_req <= 1'b0;
      wake_req <= 1'b1;
      n = 0;
      while (power_mode !== SMCS_RUN && n < 300)
      begin
         @(posedge pclk);
         n++;
      end
      wake_req <= 1'b0;
      chk("fast wake run", {29'h0, power_mode}, 32'h0000_0000);
      chk("fast wake clock", {31'h0, sys_clk_select_slow}, 32'h0000_0001);
      apb(1'b0, SMCS_MODE_CTRL_ADDR, 32'h0000_0000);
      chk("xtal not ready", rd & 32'h0000_0004, 32'h0000_0000);
      n = 0;
      while (sys_clk_select_slow !== 1'b0 && n < 8000)
      begin
         @(posedge pclk);
         n++;
      end
      // 1024 crystal ticks at six pclk cycles each, less the few cycles spent above
      chk("xtal settle", {31'h0, n > 6100 && n < 6200}, 32'h0000_0001);
      apb(1'b0, SMCS_MODE_CTRL_ADDR, 32'h0000_0000);
      chk("xtal ready", rd & 32'h0000_000c, 32'h0000_000c);
      xtal_source <= 1'b0;
      $display("test fast wake done");
   endtask

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset_regs();
      t_divider();
      t_halt(8'h03, 1'b1, 1'b0, 3'h1, 1'b1, 8'h00);
      t_halt(8'h03, 1'b0, 1'b0, 3'h2, 1'b0, 8'h04);
      t_halt(8'h01, 1'b0, 1'b1, 3'h3, 1'b0, 8'h04);
      t_halt(8'h01, 1'b0, 1'b0, 3'h4, 1'b0, 8'h0c);
      t_fast_wake();
      complete_run();
   end

   // the whole run needs about 10000 cycles; a hang is cut off well beyond that
   initial
   begin
      repeat (50000) @(posedge pclk);
      err_total++;
      complete_run();
   end
endmodule

// File: hw/smcs_sync.sv
// two flip-flop synchroniser for single-bit levels
`timescale 1ns/10ps
module smcs_sync #(parameter int W = 1)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// File: hw/smcs_top.sv
// system clock and power mode select with apb register access
// ----------------------------------------
// How it works
// RULE_01 - select bit 1 gives undivided fast clock, 0 uses divider field choice
// RULE_02 - moving from fast to slow clock stops the fast oscillator
// RULE_03 - divider field bits 7..5: 001 slow clock, higher codes faster divided clock
// RULE_04 - fast wake on crystal runs from slow rc clock right after wake
// RULE_05 - slow ready reads 0 in deep stop, sets 1..2 slow cycles after wake
// RULE_06 - fast ready cleared at power-on, set once fast oscillator is stable
// RULE_07 - fast ready 0 in stop and clock-off idle, crystal sets after 1024 cycles
// RULE_08 - halt enters idle when idle bit is 1, stop otherwise
// RULE_09 - idle keeps system clock if keep bit set, else stops it too
// RULE_10 - select 0 with field 000 or 001 runs slow mode from slow clock
// RULE_11 - with fast rc, wake takes 15..16 cycles and fast wake is ignored
// RULE_12 - fast wake on crystal runs slow until 1024 crystal cycles, then switches
// RULE_13 - code 010 divides by 64, each higher code halves down to 2 at 111
// RULE_14 - writes to both ready flags are ignored
// ----------------------------------------
`timescale 1ns/10ps
module smcs_top
   import smcs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic halt_req,
   input wire logic wake_req,
   input wire logic idle_clock_keep,
   input wire logic wdt_enable,
   input wire logic xtal_source,
   input wire logic fast_osc_tick,
   input wire logic slow_osc_tick,
   output logic fast_osc_enable,
   output logic slow_osc_enable,
   output logic sys_clk_select_slow,
   output logic [5:0] sys_clk_divide,
   output logic cpu_run,
   output logic sys_clk_run,
   output logic [2:0] power_mode
);
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [4:0] raw_in;
   logic [4:0] syn_in;
   logic fast_tick_q;
   logic slow_tick_q;
   logic fast_edge;
   logic slow_edge;
   assign raw_in = {halt_req, wake_req, idle_clock_keep, wdt_enable, fast_osc_tick};
   smcs_sync #(.W(5)) u_sync (.pclk(pclk), .presetn(presetn), .async_in(raw_in),
      .sync_out(syn_in));
   logic slow_syn;
   smcs_sync #(.W(1)) u_sync_slow (.pclk(pclk), .presetn(presetn),
      .async_in(slow_osc_tick), .sync_out(slow_syn));
   logic halt_s;
   logic wake_s;
   logic keep_s;
   logic wdt_s;
   logic halt_q;
   assign halt_s = syn_in[4];
   assign wake_s = syn_in[3];
   assign keep_s = syn_in[2];
   assign wdt_s = syn_in[1];
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fast_tick_q <= 1'b0;
         slow_tick_q <= 1'b0;
         halt_q <= 1'b0;
      end
      else
      begin
         fast_tick_q <= syn_in[0];
         slow_tick_q <= slow_syn;
         halt_q <= halt_s;
      end
   end
   assign fast_edge = syn_in[0] & ~fast_tick_q;
   assign slow_edge = slow_syn & ~slow_tick_q;
   // ----------------------------------------
   // control register and apb slave
   // ----------------------------------------
   logic [7:0] ctrl_q;
   logic hrdy_q;
   logic lrdy_q;
   logic [1:0] evt_q;
   logic wr_acc;
   logic rd_acc;
   logic [2:0] div_sel;
   logic hl_sel;
   assign wr_acc = psel & penable & pwrite & pready;
   assign rd_acc = psel & ~penable & ~pwrite;
   assign div_sel = ctrl_q[SMCS_DIV_LSB +: 3];
   assign hl_sel = ctrl_q[SMCS_HLSEL_BIT];
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_q <= SMCS_MODE_CTRL_RESET & SMCS_WRITE_MASK;
      else if (wr_acc && paddr == SMCS_MODE_CTRL_ADDR)
         ctrl_q <= pwdata[7:0] & SMCS_WRITE_MASK; // RULE_14
   end
   logic [31:0] rd_d;
   always_comb
   begin
      rd_d = 32'h0000_0000;
      unique case (paddr)
         SMCS_MODE_CTRL_ADDR: rd_d = {24'h00_0000, ctrl_q[7:4], lrdy_q, hrdy_q, ctrl_q[1:0]};
         SMCS_STATUS_ADDR: rd_d = {26'h000_0000, power_mode, fast_osc_enable,
            slow_osc_enable, sys_clk_select_slow};
         SMCS_EVENT_ADDR: rd_d = {30'h0000_0000, evt_q};
         default: rd_d = 32'h0000_0000;
      endcase
   end
   logic bad_addr;
   assign bad_addr = paddr != SMCS_MODE_CTRL_ADDR && paddr != SMCS_STATUS_ADDR
      && paddr != SMCS_EVENT_ADDR;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & bad_addr;
         if (rd_acc)
            prdata <= rd_d;
      end
   end
   // ----------------------------------------
   // mode sequencer
   // ----------------------------------------
   smcs_mode_e mode_q;
   logic [10:0] xcnt_q;
   logic [4:0] fcnt_q;
   logic [1:0] scnt_q;
   logic slow_run;
   logic fast_wake;
   logic halt_rise;
   assign halt_rise = halt_s & ~halt_q;
   assign slow_run = ~hl_sel
      && (div_sel == SMCS_DIV_SLOW0 || div_sel == SMCS_DIV_SLOW1); // RULE_10
   assign fast_wake = ctrl_q[SMCS_FAST_BIT] & xtal_source & (mode_q != SMCS_DEEP_STOP); // RULE_04
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mode_q <= SMCS_RUN;
      else
      begin
         unique case (mode_q)
            SMCS_RUN:
               if (halt_rise)
               begin
                  if (ctrl_q[SMCS_IDLE_BIT]) // RULE_08
                     mode_q <= keep_s ? SMCS_IDLE_ON : SMCS_IDLE_OFF; // RULE_09
                  else
                     mode_q <= wdt_s ? SMCS_STOP_WDT : SMCS_DEEP_STOP;
               end
            SMCS_IDLE_ON, SMCS_IDLE_OFF, SMCS_STOP_WDT, SMCS_DEEP_STOP:
               if (wake_s)
                  mode_q <= SMCS_WAKE;
            SMCS_WAKE:
               if (lrdy_q && (slow_run || hrdy_q || fast_wake))
                  mode_q <= SMCS_RUN;
         endcase
      end
   end
   logic off_mode;
   assign off_mode = mode_q == SMCS_IDLE_OFF || mode_q == SMCS_STOP_WDT
      || mode_q == SMCS_DEEP_STOP;
   // ----------------------------------------
   // oscillator ready flags
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hrdy_q <= 1'b0; // RULE_06
         xcnt_q <= 11'h000;
         fcnt_q <= 5'h00;
      end
      else if (off_mode || slow_run)
      begin
         hrdy_q <= 1'b0; // RULE_07
         xcnt_q <= 11'h000;
         fcnt_q <= 5'h00;
      end
      else if (!hrdy_q && fast_edge)
      begin
         if (xtal_source)
         begin
            xcnt_q <= xcnt_q + 11'h001;
            hrdy_q <= (xcnt_q + 11'h001) == SMCS_XTAL_STABLE; // RULE_07 RULE_12
         end
         else
         begin
            fcnt_q <= fcnt_q + 5'h01;
            hrdy_q <= (fcnt_q + 5'h01) == SMCS_FRC_WAKE; // RULE_11
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lrdy_q <= 1'b0;
         scnt_q <= 2'h0;
      end
      else if (mode_q == SMCS_DEEP_STOP)
      begin
         lrdy_q <= 1'b0; // RULE_05
         scnt_q <= 2'h0;
      end
      else if (!lrdy_q && slow_edge)
      begin
         scnt_q <= scnt_q + 2'h1;
         lrdy_q <= (scnt_q + 2'h1) == SMCS_SRC_WAKE; // RULE_05
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         evt_q <= 2'h0;
      else
      begin
         evt_q[SMCS_EVT_HALT_BIT] <= mode_q != SMCS_RUN && mode_q != SMCS_WAKE;
         evt_q[SMCS_EVT_WAKE_BIT] <= mode_q == SMCS_WAKE;
      end
   end
   // ----------------------------------------
   // clock selection outputs
   // ----------------------------------------
   logic [5:0] div_d;
   always_comb
   begin
      div_d = 6'h00;
      if (!hl_sel && !slow_run)
         // first fast code keeps all six bits (divide by 64), each code above halves it
         div_d = SMCS_DIV_MAX >> (div_sel - SMCS_DIV_SLOW1 - 3'h1); // RULE_13 RULE_03
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fast_osc_enable <= 1'b1;
         slow_osc_enable <= 1'b1;
         sys_clk_select_slow <= 1'b0;
         sys_clk_divide <= 6'h00;
         cpu_run <= 1'b1;
         sys_clk_run <= 1'b1;
         power_mode <= 3'h0;
      end
      else
      begin
         fast_osc_enable <= ~slow_run & ~off_mode; // RULE_02
         slow_osc_enable <= mode_q != SMCS_DEEP_STOP;
         // fast wake stays on the slow clock in run until the crystal is counted stable
         sys_clk_select_slow <= slow_run || (fast_wake && !hrdy_q
            && (mode_q == SMCS_WAKE || mode_q == SMCS_RUN)); // RULE_12 RULE_04
         sys_clk_divide <= hl_sel ? 6'h00 : div_d; // RULE_01
         cpu_run <= mode_q == SMCS_RUN;
         sys_clk_run <= ~off_mode; // RULE_09
         power_mode <= mode_q;
      end
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   chk_ready_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc |=> ctrl_q[SMCS_HRDY_BIT] == 1'b0 && ctrl_q[SMCS_LRDY_BIT] == 1'b0) // RULE_14
      else $error("ready flag bits stored by write");
   chk_deep_stop_lrdy: assert property (@(posedge pclk) disable iff (!presetn)
      mode_q == SMCS_DEEP_STOP |=> !lrdy_q) // RULE_05
      else $error("slow ready high in deep stop");
   chk_off_hrdy_low: assert property (@(posedge pclk) disable iff (!presetn)
      off_mode |=> !hrdy_q) // RULE_07
      else $error("fast ready high while clock off");
   chk_halt_idle_entry: assert property (@(posedge pclk) disable iff (!presetn)
      mode_q == SMCS_RUN && halt_rise && ctrl_q[SMCS_IDLE_BIT]
      |=> mode_q == SMCS_IDLE_ON || mode_q == SMCS_IDLE_OFF) // RULE_08
      else $error("halt with idle bit did not enter idle");
   chk_halt_stop_entry: assert property (@(posedge pclk) disable iff (!presetn)
      mode_q == SMCS_RUN && halt_rise && !ctrl_q[SMCS_IDLE_BIT]
      |=> mode_q == SMCS_STOP_WDT || mode_q == SMCS_DEEP_STOP) // RULE_08
      else $error("halt without idle bit did not stop");
   chk_idle_keep_clock: assert property (@(posedge pclk) disable iff (!presetn)
      mode_q == SMCS_IDLE_ON |=> sys_clk_run && !cpu_run) // RULE_09
      else $error("clock-on idle clock state wrong");
   chk_slow_stops_fast: assert property (@(posedge pclk) disable iff (!presetn)
      slow_run |=> !fast_osc_enable && sys_clk_select_slow) // RULE_02 RULE_10
      else $error("slow mode left fast oscillator on");
   chk_fast_full_clock: assert property (@(posedge pclk) disable iff (!presetn)
      hl_sel |=> sys_clk_divide == 6'h00) // RULE_01
      else $error("full clock select divided");
   chk_div64_code: assert property (@(posedge pclk) disable iff (!presetn)
      !hl_sel && div_sel == 3'h2 |=> sys_clk_divide == 6'h3f) // RULE_13 RULE_03
      else $error("code 010 not divide by 64");
   chk_fast_wake_slow: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == SMCS_WAKE || mode_q == SMCS_RUN) && fast_wake && !hrdy_q
      |=> sys_clk_select_slow) // RULE_04 RULE_12
      else $error("fast wake not on slow clock");
   chk_power_on_hrdy: assert property (@(posedge pclk)
      !presetn |=> !hrdy_q) // RULE_06
      else $error("fast ready set at reset");
   chk_frc_wake_count: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(hrdy_q) && !xtal_source |-> fcnt_q == SMCS_FRC_WAKE) // RULE_11
      else $error("fast rc ready count wrong");
endmodule

// File: include/smcs_pkg.sv
// package of register layout, reset values and timing counts for the clock mode select block
package smcs_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [11:0] SMCS_MODE_CTRL_ADDR = 12'h000;
   localparam logic [11:0] SMCS_STATUS_ADDR = 12'h004;
   localparam logic [11:0] SMCS_EVENT_ADDR = 12'h008;
   localparam logic [7:0] SMCS_MODE_CTRL_RESET = 8'h03;
   localparam logic [7:0] SMCS_WRITE_MASK = 8'hf3;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int SMCS_HLSEL_BIT = 0;
   localparam int SMCS_IDLE_BIT = 1;
   localparam int SMCS_HRDY_BIT = 2;
   localparam int SMCS_LRDY_BIT = 3;
   localparam int SMCS_FAST_BIT = 4;
   localparam int SMCS_DIV_LSB = 5;
   localparam int SMCS_EVT_HALT_BIT = 0;
   localparam int SMCS_EVT_WAKE_BIT = 1;
   // ----------------------------------------
   // divider codes and timing
   // ----------------------------------------
   localparam logic [2:0] SMCS_DIV_SLOW0 = 3'h0;
   localparam logic [2:0] SMCS_DIV_SLOW1 = 3'h1;
   localparam logic [2:0] SMCS_DIV_TOP = 3'h7;
   localparam logic [10:0] SMCS_XTAL_STABLE = 11'h400;
   localparam logic [4:0] SMCS_FRC_WAKE = 5'h10;
   localparam logic [1:0] SMCS_SRC_WAKE = 2'h2;
   localparam logic [5:0] SMCS_DIV_MAX = 6'h3f;
   typedef enum logic [2:0] {SMCS_RUN, SMCS_IDLE_ON, SMCS_IDLE_OFF, SMCS_STOP_WDT,
      SMCS_DEEP_STOP, SMCS_WAKE} smcs_mode_e;
endpackage
